/* File: rtl/fesc_pkg.sv */
// constants, carriers and states shared by the fault event register block
// assumes: single core clock, byte-wide registers behind a serial slave port
package fesc_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] FESC_OFS_EV1 = 8'h01; // first event byte, read clears
	localparam logic [7:0] FESC_OFS_EV2 = 8'h02; // second event byte, read clears
	localparam logic [7:0] FESC_OFS_STAT = 8'h03; // live status flags
	localparam logic [7:0] FESC_OFS_RSVD = 8'h04; // reserved slot, no function
	localparam logic [7:0] FESC_OFS_CMD = 8'h05; // action trigger
	localparam logic [7:0] FESC_OFS_MSK1 = 8'h06; // suppress mask for first event byte
	localparam logic [7:0] FESC_OFS_MSK2 = 8'h07; // suppress mask for second event byte
	localparam logic [7:0] FESC_OFS_CFG1 = 8'h08; // configuration byte with mask-all
	// ----------------------------------------
	// field layouts and reset values
	// ----------------------------------------
	localparam logic [7:0] FESC_EV1_USED = 8'hbd; // bits 7,5,4,3,2,0
	localparam logic [7:0] FESC_EV2_USED = 8'h7f; // bit 7 unused
	localparam logic [7:0] FESC_STAT_USED = 8'hfc; // bits 1,0 unused
	localparam logic [7:0] FESC_CFG1_USED = 8'hf8; // bits 2..0 unused
	localparam int FESC_CMD_APPLY_BIT = 1; // load staged voltage code
	localparam int FESC_CMD_ENABLE_BIT = 0; // enable main converter
	localparam int FESC_CFG1_MASK_ALL_BIT = 5; // global mask override
	localparam logic [7:0] FESC_EV_RESET = 8'h00;
	localparam logic [7:0] FESC_MASK_RESET = 8'h00;
	localparam logic [7:0] FESC_CFG1_RESET = 8'h28; // mask-all set after reset
	localparam logic [7:0] FESC_READ_ZERO = 8'h00; // unmapped and reserved reads
	localparam logic [10:0] FESC_VCODE_RESET = 11'h190; // applied voltage code after reset
	localparam logic [3:0] FESC_BITS_PER_BYTE = 4'h8; // data bits before the ack slot
	localparam logic [6:0] FESC_DEFAULT_ADDR = 7'h2a; // slave address, arbitrary value
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic mode_change; // 7: current/voltage regulation swap
		logic pad6; // 6: unused
		logic sync_out_of_range; // 5: external sync clock out of range
		logic frequency_set_resistor_range; // 4: resistor probed out of range
		logic thermal_shutdown_hard; // 3
		logic thermal_shutdown_soft; // 2
		logic pad1; // 1: unused
		logic input_overvoltage_lockout; // 0
	} fesc_ev1_t;
	typedef struct packed {
		logic pad7; // 7: unused
		logic main_overcurrent; // 6
		logic main_overvoltage; // 5
		logic main_undervoltage; // 4: either cv or cc threshold
		logic aux_regulator_undervoltage; // 3
		logic bias_rail_overcurrent; // 2
		logic bias_rail_overvoltage; // 1
		logic bias_rail_undervoltage; // 0
	} fesc_ev2_t;
	typedef struct packed {
		logic sync_rate_too_fast; // 7
		logic sync_rate_too_slow; // 6
		logic bias_rail_full_duty; // 5
		logic main_current_mode; // 4: 1 current, 0 voltage regulation
		logic main_full_duty; // 3
		logic output_power_good; // 2
		logic [1:0] pad; // 1..0 unused
	} fesc_stat_t;
	// ----------------------------------------
	// serial slave states
	// ----------------------------------------
	typedef enum logic [2:0] {
		FESC_IDLE,
		FESC_ADDR,
		FESC_PTR,
		FESC_WDATA,
		FESC_RDATA,
		FESC_IGNORE
	} fesc_state_t;
endpackage

/* File: rtl/fesc_regs.sv */
// fault event, status, command and mask registers behind a two-wire serial slave
// assumes: fault causes and status levels arrive asynchronously from analog blocks,
// the staged voltage code comes from logic on clk_i, sda is open drain outside
//
// Summary of operation
// - event2 bit6 set on main overcurrent
// - event2 bit5 set on main overvoltage
// - event2 bit4 set on main undervoltage
// - event2 bit3 set on aux regulator undervoltage
// - event2 bit2 set on bias rail overcurrent
// - bits1/0 bias over/undervoltage; bit7 reads zero
// - status byte live, read-only, bits1:0 zero
// - status bits7/6 sync rate fast/slow
// - status bit5 bias rail full duty
// - status bit4 current regulation mode
// - status bit3 main full duty
// - status bit2 output power good
// - location 4 reserved, reads zero, ignores writes
// - command write triggers bits written one
// - command bit1 applies staged code, reads zero
// - command bit0 enables main converter, resets zero
// - two masks map onto two event bytes
// - set mask bit blocks its interrupt
// - mask-all forces every mask bit one
// - mask1 bits 6 and 1 unused
// - read clears event bits whose cause ended
// - event1 bit layout of first byte
// - mask-all defaults to one after reset
`timescale 1ns/1ps
`default_nettype none
module fesc_regs #(
	parameter logic [6:0] SLAVE_ADDR = fesc_pkg::FESC_DEFAULT_ADDR // arbitrary default
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire fesc_pkg::fesc_ev1_t ev1_cause_i,
	input wire fesc_pkg::fesc_ev2_t ev2_cause_i,
	input wire fesc_pkg::fesc_stat_t stat_i,
	input wire logic [10:0] staged_code_i,
	output logic [10:0] output_voltage_code_o,
	output logic apply_voltage_code_o,
	output logic main_enable_o,
	output logic irq_o
);
	import fesc_pkg::*;

	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	// reserved general-call address cannot be served as a plain slave
	if (SLAVE_ADDR == 7'h00) begin : g_bad_addr
		$error("slave address zero is not allowed");
	end

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic scl_m, scl_s, scl_d; // scl meta, sync, delayed
	logic sda_m, sda_s, sda_d; // sda meta, sync, delayed
	fesc_ev1_t ev1_m, ev1_s; // first event causes
	fesc_ev2_t ev2_m, ev2_s; // second event causes
	fesc_stat_t stat_m, stat_s; // live status levels

	// two flops on every asynchronous level, a third on scl and sda for edge detection; the first stage is never read
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			{scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3f; // idle bus levels
			{ev1_m, ev1_s, ev2_m, ev2_s, stat_m, stat_s} <= 48'h0; // no causes
		end else begin
			{scl_d, scl_s, scl_m} <= {scl_s, scl_m, scl_i};
			{sda_d, sda_s, sda_m} <= {sda_s, sda_m, sda_i};
			{ev1_s, ev1_m} <= {ev1_m, ev1_cause_i};
			{ev2_s, ev2_m} <= {ev2_m, ev2_cause_i};
			{stat_s, stat_m} <= {stat_m, stat_i};
		end
	end
	// bus conditions from the settled copies
	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] ev1_reg; // first event byte
	logic [7:0] ev2_reg; // second event byte
	logic [7:0] msk1_reg; // first suppress mask
	logic [7:0] msk2_reg; // second suppress mask
	logic [7:0] cfg1_reg; // configuration byte with mask-all
	logic enable_reg; // main converter enable
	logic apply_reg; // one-cycle apply pulse
	logic [10:0] vcode_reg; // voltage code in effect
	logic irq_reg; // interrupt output
	logic sda_o_reg; // open-drain data level, always low

	// serial engine
	fesc_state_t state_reg;
	logic [3:0] bit_cnt_reg; // rising edges seen in this byte
	logic ack_slot_reg; // inside the ninth bit
	logic rw_reg; // 1 read transfer
	logic [7:0] ptr_reg; // register pointer, auto increments
	logic [7:0] rx_reg; // received byte
	logic [7:0] tx_reg; // byte being sent
	logic mst_nack_reg; // host declined further read data
	logic sda_oe_n_reg; // low pulls sda low
	logic wr_stb_reg; // one-cycle register write
	logic [7:0] wr_addr_reg;
	logic [7:0] wr_data_reg;
	logic rd_clr1_reg; // first event byte was just loaded for read
	logic rd_clr2_reg; // second event byte was just loaded for read

	// ----------------------------------------
	// read data mux
	// ----------------------------------------
	logic [7:0] rd_val;
	always_comb begin
		rd_val = FESC_READ_ZERO;
		case (ptr_reg)
			FESC_OFS_EV1: rd_val = ev1_reg;
			FESC_OFS_EV2: rd_val = ev2_reg;
			FESC_OFS_STAT: rd_val = stat_s & FESC_STAT_USED;
			FESC_OFS_CMD: rd_val = {7'h00, enable_reg};
			FESC_OFS_MSK1: rd_val = msk1_reg;
			FESC_OFS_MSK2: rd_val = msk2_reg;
			FESC_OFS_CFG1: rd_val = cfg1_reg;
			default: rd_val = FESC_READ_ZERO;
		endcase
	end
	// ----------------------------------------
	// serial slave engine
	// ----------------------------------------
	// bytes are taken on scl rise; sda only changes on scl fall so we never
	// fake a start or stop while the host holds scl high
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg <= FESC_IDLE;
			bit_cnt_reg <= 4'h0;
			{ack_slot_reg, rw_reg, mst_nack_reg} <= 3'b000;
			sda_oe_n_reg <= 1'b1; // sda released
			{wr_stb_reg, rd_clr1_reg, rd_clr2_reg} <= 3'b000; // no pulses
			{ptr_reg, rx_reg, tx_reg, wr_addr_reg, wr_data_reg} <= 40'h0;
		end else begin
			wr_stb_reg <= 1'b0;
			rd_clr1_reg <= 1'b0;
			rd_clr2_reg <= 1'b0;
			if (bus_start) begin
				// start or repeated start: pointer is kept
				state_reg <= FESC_ADDR;
				bit_cnt_reg <= 4'h0;
				ack_slot_reg <= 1'b0;
				sda_oe_n_reg <= 1'b1;
			end else if (bus_stop) begin
				state_reg <= FESC_IDLE;
				ack_slot_reg <= 1'b0;
				sda_oe_n_reg <= 1'b1;
			end else if (state_reg != FESC_IDLE && state_reg != FESC_IGNORE) begin
				if (scl_rise) begin
					if (bit_cnt_reg == FESC_BITS_PER_BYTE) begin
						mst_nack_reg <= sda_s; // host ack slot
						bit_cnt_reg <= 4'h0;
					end else begin
						rx_reg <= {rx_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end else if (scl_fall) begin
					if (bit_cnt_reg == FESC_BITS_PER_BYTE && !ack_slot_reg) begin
						ack_slot_reg <= 1'b1;
						case (state_reg)
							FESC_ADDR: begin
								if (rx_reg[7:1] == SLAVE_ADDR) begin
									sda_oe_n_reg <= 1'b0;
									rw_reg <= rx_reg[0];
								end else begin
									state_reg <= FESC_IGNORE; // not for us
								end
							end
							FESC_PTR: begin
								ptr_reg <= rx_reg;
								sda_oe_n_reg <= 1'b0;
							end
							FESC_WDATA: begin
								wr_stb_reg <= 1'b1;
								wr_addr_reg <= ptr_reg;
								wr_data_reg <= rx_reg;
								ptr_reg <= ptr_reg + 8'h01;
								sda_oe_n_reg <= 1'b0;
							end
							default: begin
								sda_oe_n_reg <= 1'b1; // read: host acks
							end
						endcase
					end else if (bit_cnt_reg == 4'h0 && ack_slot_reg) begin
						ack_slot_reg <= 1'b0;
						if ((state_reg == FESC_ADDR && rw_reg) ||
							(state_reg == FESC_RDATA && !mst_nack_reg)) begin
							// load next byte; event bytes clear one clock after this load
							state_reg <= FESC_RDATA;
							tx_reg <= rd_val;
							rd_clr1_reg <= (ptr_reg == FESC_OFS_EV1);
							rd_clr2_reg <= (ptr_reg == FESC_OFS_EV2);
							ptr_reg <= ptr_reg + 8'h01;
							sda_oe_n_reg <= rd_val[7];
						end else if (state_reg == FESC_RDATA) begin
							state_reg <= FESC_IGNORE; // host ended the read
							sda_oe_n_reg <= 1'b1;
						end else begin
							sda_oe_n_reg <= 1'b1;
							if (state_reg == FESC_ADDR) begin
								state_reg <= FESC_PTR;
							end else if (state_reg == FESC_PTR) begin
								state_reg <= FESC_WDATA;
							end
						end
					end else if (state_reg == FESC_RDATA && !ack_slot_reg) begin
						// shift out next data bit, msb first
						sda_oe_n_reg <= tx_reg[3'(4'h7 - bit_cnt_reg)];
					end
				end
			end
		end
	end
	// ----------------------------------------
	// event bytes
	// ----------------------------------------
	// causes still present re-set in the same cycle, so a read never loses
	// an event that is active while the byte is being cleared
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			{ev1_reg, ev2_reg} <= {FESC_EV_RESET, FESC_EV_RESET};
		end else begin
			ev1_reg <= ((rd_clr1_reg ? (ev1_reg & ev1_s) : ev1_reg) | ev1_s)
				& FESC_EV1_USED;
			ev2_reg <= ((rd_clr2_reg ? (ev2_reg & ev2_s) : ev2_reg) | ev2_s)
				& FESC_EV2_USED;
		end
	end
	// ----------------------------------------
	// masks and configuration
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			msk1_reg <= FESC_MASK_RESET;
			msk2_reg <= FESC_MASK_RESET;
			cfg1_reg <= FESC_CFG1_RESET;
		end else if (wr_stb_reg) begin
			case (wr_addr_reg)
				FESC_OFS_MSK1: msk1_reg <= wr_data_reg & FESC_EV1_USED;
				FESC_OFS_MSK2: msk2_reg <= wr_data_reg & FESC_EV2_USED;
				FESC_OFS_CFG1: cfg1_reg <= wr_data_reg & FESC_CFG1_USED;
				default: begin
				end // reserved and read-only locations ignore writes
			endcase
		end
	end
	// ----------------------------------------
	// command actions
	// ----------------------------------------
	// apply is a pulse only; the command byte never stores it
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			enable_reg <= 1'b0;
			apply_reg <= 1'b0;
		end else begin
			apply_reg <= wr_stb_reg && wr_addr_reg == FESC_OFS_CMD &&
				wr_data_reg[FESC_CMD_APPLY_BIT];
			if (wr_stb_reg && wr_addr_reg == FESC_OFS_CMD) begin
				enable_reg <= wr_data_reg[FESC_CMD_ENABLE_BIT];
			end
		end
	end
	// voltage code in effect follows the staged code only on apply
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			vcode_reg <= FESC_VCODE_RESET;
		end else if (apply_reg) begin
			vcode_reg <= staged_code_i;
		end
	end
	// ----------------------------------------
	// interrupt
	// ----------------------------------------
	logic [7:0] eff_msk1, eff_msk2; // masks after mask-all override
	assign eff_msk1 = cfg1_reg[FESC_CFG1_MASK_ALL_BIT] ? 8'hff : msk1_reg;
	assign eff_msk2 = cfg1_reg[FESC_CFG1_MASK_ALL_BIT] ? 8'hff : msk2_reg;
	// any unmasked latched event raises the line one clock later
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			{irq_reg, sda_o_reg} <= 2'b00;
		end else begin
			irq_reg <= |(ev1_reg & ~eff_msk1) | |(ev2_reg & ~eff_msk2);
			sda_o_reg <= 1'b0; // open drain only ever pulls low
		end
	end
	assign sda_o = sda_o_reg;
	assign sda_oe_n_o = sda_oe_n_reg;
	assign output_voltage_code_o = vcode_reg;
	assign apply_voltage_code_o = apply_reg;
	assign main_enable_o = enable_reg;
	assign irq_o = irq_reg;
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_cmd_apply;
		wr_stb_reg && wr_addr_reg == FESC_OFS_CMD && wr_data_reg[FESC_CMD_APPLY_BIT];
	endsequence
	sequence s_apply_pulse;
		apply_voltage_code_o ##1 !apply_voltage_code_o;
	endsequence
	property p_ev2_ovc;
		@(posedge clk_i) disable iff (srst_i) ev2_s.main_overcurrent |=> ev2_reg[6];
	endproperty
	a_ev2_ovc: assert property (p_ev2_ovc) else $error("overcurrent not latched");
	property p_ev2_uv;
		@(posedge clk_i) disable iff (srst_i) ev2_s.main_undervoltage [*2] |-> ev2_reg[4] ##1 ev2_reg[4];
	endproperty
	a_ev2_uv: assert property (p_ev2_uv) else $error("undervoltage not latched");
	property p_ev2_bit7;
		@(posedge clk_i) disable iff (srst_i) !ev2_reg[7] && !ev1_reg[6] && !ev1_reg[1];
	endproperty
	a_ev2_bit7: assert property (p_ev2_bit7) else $error("unused event bit set");
	property p_clear;
		@(posedge clk_i) disable iff (srst_i) (rd_clr2_reg && ev2_s == '0) |=> ev2_reg == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("event byte not cleared");
	property p_apply;
		@(posedge clk_i) disable iff (srst_i) s_cmd_apply |=> s_apply_pulse ##0 1'b1 ##1
			output_voltage_code_o == $past(staged_code_i, 2);
	endproperty
	a_apply: assert property (p_apply) else $error("apply pulse or code wrong");
	property p_enable;
		@(posedge clk_i) disable iff (srst_i) (wr_stb_reg && wr_addr_reg == FESC_OFS_CMD)
			|=> main_enable_o == $past(wr_data_reg[FESC_CMD_ENABLE_BIT]);
	endproperty
	a_enable: assert property (p_enable) else $error("enable not taken");
	property p_mask_all;
		@(posedge clk_i) disable iff (srst_i) cfg1_reg[FESC_CFG1_MASK_ALL_BIT] [*2] |-> !irq_o;
	endproperty
	a_mask_all: assert property (p_mask_all) else $error("irq despite mask all");
	property p_irq;
		@(posedge clk_i) disable iff (srst_i) (ev2_reg[6] && !eff_msk2[6]) |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("unmasked event gave no irq");
	property p_rsvd;
		@(posedge clk_i) disable iff (srst_i) (ptr_reg == FESC_OFS_RSVD) |-> rd_val == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved slot reads nonzero");
	property p_msk1_unused;
		@(posedge clk_i) disable iff (srst_i) !msk1_reg[6] && !msk1_reg[1];
	endproperty
	a_msk1_unused: assert property (p_msk1_unused) else $error("unused mask bit set");
	property p_reset_mask;
		@(posedge clk_i) $fell(srst_i) |-> cfg1_reg[FESC_CFG1_MASK_ALL_BIT] && !irq_o;
	endproperty
	a_reset_mask: assert property (p_reset_mask) else $error("mask all not set at reset");
endmodule
`default_nettype wire

/* File: sim/fesc_host.sv */
// two-wire host model that reaches the fault event register block
// assumes: bench clock paces every edge, sda wire is resolved by the bench with a pull-up
`timescale 1ns/1ps
`default_nettype none
module fesc_host #(
	parameter logic [6:0] ADDR = fesc_pkg::FESC_DEFAULT_ADDR
) (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o,
	output logic [7:0] rd_data_o,
	output logic rd_stb_o,
	output logic [7:0] nak_cnt_o
);
	import fesc_pkg::*;
	// ----------------------------------------
	// idle bus: both lines released
	// ----------------------------------------
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		rd_data_o = 8'h00;
		rd_stb_o = 1'b0;
		nak_cnt_o = 8'h00;
	end
	task automatic hc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// sda moves 4 clocks after scl falls, so the synchronised edges never race
	task automatic tx(input logic v);
		sda_o <= v;
		hc(4);
		scl_o <= 1'b1;
		hc(8);
		scl_o <= 1'b0;
		hc(4);
	endtask
	// sampled mid high phase, well after the device drive settles
	task automatic rx(output logic v);
		sda_o <= 1'b1;
		hc(4);
		scl_o <= 1'b1;
		hc(4);
		v = sda_i;
		hc(4);
		scl_o <= 1'b0;
		hc(4);
	endtask
	// start and repeated start share one shape
	task automatic start;
		sda_o <= 1'b1;
		hc(4);
		scl_o <= 1'b1;
		hc(8);
		sda_o <= 1'b0;
		hc(8);
		scl_o <= 1'b0;
		hc(4);
	endtask
	task automatic stop;
		sda_o <= 1'b0;
		hc(4);
		scl_o <= 1'b1;
		hc(8);
		sda_o <= 1'b1;
		hc(8);
	endtask
	// byte out msb first, missing ack is counted
	task automatic tx_byte(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) tx(d[i]);
		rx(a);
		if (a !== 1'b0) nak_cnt_o <= nak_cnt_o + 8'h01;
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		start;
		tx_byte({ADDR, 1'b0});
		tx_byte(ptr);
		tx_byte(d);
		stop;
	endtask
	// pointer write, repeated start, one byte then nack
	task automatic rd(input logic [7:0] ptr);
		logic [7:0] d;
		start;
		tx_byte({ADDR, 1'b0});
		tx_byte(ptr);
		start;
		tx_byte({ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) rx(d[i]);
		tx(1'b1);
		stop;
		rd_data_o <= d;
		rd_stb_o <= 1'b1;
		hc(1);
		rd_stb_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: sim/fault_event_status_command_regs_bench.sv */
// self-checking bench for the fault event register block
// assumes: host model drives the serial port, bench drives causes and status levels
`timescale 1ns/1ps
`default_nettype none
module fault_event_status_command_regs_bench;
	import fesc_pkg::*;
	logic clk = 1'b0;
	logic srst, scl, sda_h, sda_d, sda_oe_n, rd_stb, apply, men, irq, ap_d;
	fesc_ev1_t ev1;
	fesc_ev2_t ev2;
	fesc_stat_t stat;
	logic [10:0] staged, code;
	logic [7:0] rd_data, nak, m, u;
	wire logic sda_w;
	int error_cnt = 0;
	int checks = 0;
	int seed = 89;
	logic [7:0] rq[$]; // expected read bytes
	logic [10:0] cq[$]; // expected applied codes
	// open drain wire with pull-up
	assign sda_w = sda_h & (sda_oe_n | sda_d);
	always #4 clk = ~clk;
	fesc_regs dut (.clk_i(clk), .srst_i(srst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d),
		.sda_oe_n_o(sda_oe_n), .ev1_cause_i(ev1), .ev2_cause_i(ev2), .stat_i(stat),
		.staged_code_i(staged), .output_voltage_code_o(code), .apply_voltage_code_o(apply),
		.main_enable_o(men), .irq_o(irq));
	fesc_host host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h),
		.rd_data_o(rd_data), .rd_stb_o(rd_stb), .nak_cnt_o(nak));
	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: byte %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_code(input logic [10:0] g, input logic [10:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: code %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: level %b want %b", $time, g, e);
		end
	endtask
	task automatic final_report;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// note the expectation first, the watcher compares when the byte lands
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		host.rd(a);
	endtask
	// ----------------------------------------
	// watcher: oldest note against each result
	// ----------------------------------------
	always @(posedge clk) begin
		ap_d <= apply;
		// empty queue means an unasked result, compared against unknown to fail
		if (rd_stb) chk_byte(rd_data, rq.size() != 0 ? rq.pop_front() : 8'hxx);
		if (ap_d) chk_code(code, cq.size() != 0 ? cq.pop_front() : 11'hxxx);
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		$display("unexpected at %0t: run did not finish", $time);
		final_report;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		ev1 = '0;
		ev2 = '0;
		stat = '0;
		staged = 11'h000;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		chk_bit(irq, 1'b0);
		chk_bit(men, 1'b0);
		chk_code(code, FESC_VCODE_RESET);
		// reset values of events, status, reserved, command, masks and mask-all
		for (int a = 1; a < 9; a++) begin
			rd_exp(8'(a), (a == 8) ? FESC_CFG1_RESET : 8'h00);
		end
		host.wr(FESC_OFS_RSVD, 8'hff);
		rd_exp(FESC_OFS_RSVD, FESC_READ_ZERO);
		// live status, random levels, unused bits must read zero
		for (int i = 0; i < 4; i++) begin
			stat <= 8'($random(seed));
			repeat (8) @(posedge clk);
			rd_exp(FESC_OFS_STAT, stat & FESC_STAT_USED);
		end
		// enable plus apply, then apply alone which also drops enable
		staged <= 11'($random(seed));
		@(posedge clk);
		cq.push_back(staged);
		host.wr(FESC_OFS_CMD, 8'h03);
		chk_bit(men, 1'b1);
		rd_exp(FESC_OFS_CMD, 8'h01);
		staged <= ~staged;
		@(posedge clk);
		cq.push_back(staged);
		host.wr(FESC_OFS_CMD, 8'h02);
		chk_bit(men, 1'b0);
		// mask-all holds the line low until the host clears it
		ev2 <= 8'h40;
		repeat (10) @(posedge clk);
		chk_bit(irq, 1'b0);
		host.wr(FESC_OFS_CFG1, 8'h08);
		chk_bit(irq, 1'b1);
		ev2 <= '0;
		rd_exp(FESC_OFS_EV2, 8'h40);
		chk_bit(irq, 1'b0);
		// every bit of both event bytes against a random mask
		for (int r = 1; r <= 2; r++) begin
			m = 8'($random(seed));
			u = (r == 1) ? FESC_EV1_USED : FESC_EV2_USED;
			host.wr(8'(r + 5), m);
			rd_exp(8'(r + 5), m & u);
			for (int b = 0; b < 8; b++) begin
				if (r == 1) ev1 <= 8'h01 << b;
				else ev2 <= 8'h01 << b;
				repeat (10) @(posedge clk);
				chk_bit(irq, u[b] & ~m[b]);
				// cause still present, so the bit survives this read
				rd_exp(8'(r), u & (8'h01 << b));
				ev1 <= '0;
				ev2 <= '0;
				repeat (10) @(posedge clk);
				rd_exp(8'(r), u & (8'h01 << b));
				rd_exp(8'(r), 8'h00);
				chk_bit(irq, 1'b0);
			end
		end
		// second reset in mid-run: enable off, mask-all and reset code come back
		host.wr(FESC_OFS_CMD, 8'h01);
		chk_bit(men, 1'b1);
		srst <= 1'b1;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		chk_bit(irq, 1'b0);
		chk_bit(men, 1'b0);
		chk_code(code, FESC_VCODE_RESET);
		rd_exp(FESC_OFS_CFG1, FESC_CFG1_RESET);
		// every noted result must have been seen by the watcher
		repeat (2) @(posedge clk);
		chk_bit(rq.size() == 0 && cq.size() == 0, 1'b1);
		chk_byte(nak, 8'h00);
		final_report;
	end
endmodule
`default_nettype wire
